// ==== rtl/hbm_map.vh ====
// Constants for the host bus mastership controller.
`ifndef HBM_MAP_VH
`define HBM_MAP_VH
`define HBM_ACTION_GAP_US      500
`define HBM_CLK_MHZ            50
`define HBM_ACTION_GAP_CYC     (`HBM_ACTION_GAP_US * `HBM_CLK_MHZ)
`define HBM_INT_PULSE_CYC      4'h2
`define HBM_CID_W              5
`define HBM_CID_HI             4
`define HBM_CID_MID            3
`define HBM_CID_LO             2
`define HBM_CID_A3             1
`define HBM_CID_A2             0
`define HBM_BASE_LOW_BITS      2'h0
`define HBM_SYNC_RESET         3'h7
`endif

// ==== rtl/hbm_pin_sync.v ====
// Three-stage input synchroniser that reports a level once two stages agree.
`timescale 1ns/1ps
module hbm_pin_sync #(
	parameter RESET_LEVEL = 1'b1
) (
	// Clock and reset.
	input  wire clock_i,
	input  wire reset_i,
	// Pin and clean level.
	input  wire pin_i,
	output reg  level_o
);
	reg [2:0] stage;

	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			stage   <= {3{RESET_LEVEL}};
			level_o <= RESET_LEVEL;
		end else begin
			stage <= {stage[1:0], pin_i};
			// Only the second and third stages are compared.
			if (stage[1] == stage[2])
				level_o <= stage[2];
		end
	end
endmodule // hbm_pin_sync

// ==== rtl/hbm_base_addr.v ====
// Forms the control-section start address from the chip code.
`timescale 1ns/1ps
`include "hbm_map.vh"
module hbm_base_addr (
	// Code in.
	input  wire [4:0]  code_i,
	// Address out.
	output wire [31:0] addr_o
);
	assign addr_o = {{10{code_i[`HBM_CID_HI]}},
		{6{code_i[`HBM_CID_MID]}},
		{12{code_i[`HBM_CID_LO]}},
		code_i[`HBM_CID_A3],
		code_i[`HBM_CID_A2],
		`HBM_BASE_LOW_BITS};
endmodule // hbm_base_addr

// ==== rtl/hbm_ctrl.v ====
// Bus mastership, action and interrupt control of the host bus interface.
`timescale 1ns/1ps
`include "hbm_map.vh"
module hbm_ctrl (
	// Clock and reset.
	input  wire        clock_i,
	input  wire        reset_i,
	// Mode straps: high selects hold/acknowledge mode.
	input  wire        hold_mode_i,
	input  wire        parity_strap_i,
	input  wire [4:0]  chip_base_code_i,
	// Hold-mode arbitration.
	input  wire        bus_release_ack_i,
	output reg         bus_take_req_o,
	output reg         release_ack_passon_o,
	// Grant-mode arbitration; open-drain lines as in/out/enable.
	input  wire        mastership_grant_n_i,
	input  wire        bus_claim_n_i,
	output reg         bus_claim_n_o,
	output reg         bus_claim_oe_n_o,
	input  wire        master_claimed_n_i,
	output reg         master_claimed_n_o,
	output reg         master_claimed_oe_n_o,
	output reg         grant_passon_n_o,
	// Host action and bus fault.
	input  wire        action_trigger_n_i,
	input  wire        bus_fault_n_i,
	// Internal engine side: transfer wish, cycle status, events.
	input  wire        xfer_pending_i,
	input  wire        cycle_done_i,
	input  wire        cycle_ctrl_read_i,
	input  wire        evt_error_i,
	input  wire        evt_frame_i,
	input  wire        queue_write_i,
	output reg         bus_owned_o,
	output reg         action_req_o,
	output reg         action_fail_o,
	output reg         cycle_abort_o,
	output reg         int_pending_o,
	output reg  [31:0] ctrl_base_o,
	output reg         parity_mode_o,
	output reg         int_o
);
	localparam ST_IDLE = 2'h0;
	localparam ST_REQ  = 2'h1;
	localparam ST_OWN  = 2'h2;
	localparam ST_WAIT = 2'h3;

	wire        ack_s;
	wire        grant_n_s;
	wire        claim_n_s;
	wire        mclaim_n_s;
	wire        action_n_s;
	wire        fault_n_s;
	wire [31:0] base_addr;

	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg         action_n_d;
	reg         fault_n_d;
	reg         int_latched;
	reg         done_seen;
	reg         suspended;
	reg         captured;
	reg  [3:0]  int_cnt;
	// Next values of the registered arbitration pins.
	reg         next_take;
	reg         next_passon;
	reg         next_claim_oe_n;
	reg         next_mclaim_oe_n;
	reg         next_gpass_n;
	reg         next_owned;

	// Every arbitration, trigger and fault pin passes the three-flop filter, so a level must stand for at
	// least two clocks; shorter pulses, on the trigger too, are ignored.
	hbm_pin_sync #(.RESET_LEVEL(1'b0)) u_ack (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.pin_i   (bus_release_ack_i),
		.level_o (ack_s)
	);
	hbm_pin_sync #(.RESET_LEVEL(1'b1)) u_grant (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.pin_i   (mastership_grant_n_i),
		.level_o (grant_n_s)
	);
	hbm_pin_sync #(.RESET_LEVEL(1'b1)) u_claim (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.pin_i   (bus_claim_n_i),
		.level_o (claim_n_s)
	);
	hbm_pin_sync #(.RESET_LEVEL(1'b1)) u_mclaim (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.pin_i   (master_claimed_n_i),
		.level_o (mclaim_n_s)
	);
	hbm_pin_sync #(.RESET_LEVEL(1'b1)) u_action (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.pin_i   (action_trigger_n_i),
		.level_o (action_n_s)
	);
	hbm_pin_sync #(.RESET_LEVEL(1'b1)) u_fault (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.pin_i   (bus_fault_n_i),
		.level_o (fault_n_s)
	);

	hbm_base_addr u_base (
		.code_i (chip_base_code_i),
		.addr_o (base_addr)
	);

	// The claim pins read back our own drive too, so the lines count as free
	// only while nobody, ourselves included, pulls them low.
	wire peer_owner = !mclaim_n_s && (state != ST_OWN);
	wire lines_free = claim_n_s && mclaim_n_s;
	// The action and transfer engines share one request; a suspended
	// action holds back both until the host triggers again.
	wire want       = (xfer_pending_i || action_req_o) && !suspended;

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (want) begin
					if (hold_mode_i) begin
						if (!ack_s)
							next_state = ST_REQ;
					end else if (lines_free) begin
						next_state = ST_REQ;
					end
				end
			end
			ST_REQ: begin
				if (hold_mode_i) begin
					if (ack_s)
						next_state = ST_OWN;
				// A grant while another master still holds the bus is not ours.
				end else if (!grant_n_s && !peer_owner) begin
					next_state = ST_OWN;
				end
			end
			ST_OWN: begin
				// With no request left, we keep the bus while cycle_done_i is high and let go once it is low.
				if (!want && !cycle_done_i)
					next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (hold_mode_i ? !ack_s : lines_free)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Next pin values other than the ack pass-on follow next_state so that
	// pins and state change on one edge.
	always @* begin
		next_take = hold_mode_i &&
			((next_state == ST_REQ) || (next_state == ST_OWN));
		next_passon = hold_mode_i && ack_s && (state == ST_IDLE);
		next_claim_oe_n = !(!hold_mode_i && (next_state == ST_REQ));
		next_mclaim_oe_n = !(!hold_mode_i && (next_state == ST_OWN));
		// Hold the grant back from the edge on which we decide to claim, or
		// it would reach the next device while our own claim is low.
		if (hold_mode_i || (next_state != ST_IDLE))
			next_gpass_n = 1'b1;
		else
			next_gpass_n = grant_n_s;
		next_owned = (next_state == ST_OWN);
	end

	// Arbitration pins, all registered.
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			bus_take_req_o        <= 1'b0;
			release_ack_passon_o  <= 1'b0;
			bus_claim_n_o         <= 1'b1;
			bus_claim_oe_n_o      <= 1'b1;
			master_claimed_n_o    <= 1'b1;
			master_claimed_oe_n_o <= 1'b1;
			grant_passon_n_o      <= 1'b1;
			bus_owned_o           <= 1'b0;
		end else begin
			bus_take_req_o        <= next_take;
			release_ack_passon_o  <= next_passon;
			bus_claim_n_o         <= 1'b0;
			bus_claim_oe_n_o      <= next_claim_oe_n;
			master_claimed_n_o    <= 1'b0;
			master_claimed_oe_n_o <= next_mclaim_oe_n;
			grant_passon_n_o      <= next_gpass_n;
			bus_owned_o           <= next_owned;
		end
	end

	// Action trigger and bus fault handling.
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			action_n_d    <= 1'b1;
			fault_n_d     <= 1'b1;
			action_req_o  <= 1'b0;
			action_fail_o <= 1'b0;
			cycle_abort_o <= 1'b0;
			suspended     <= 1'b0;
		end else begin
			action_n_d    <= action_n_s;
			fault_n_d     <= fault_n_s;
			action_fail_o <= 1'b0;
			cycle_abort_o <= 1'b0;
			// Edge-detected, so a long fault level ends one cycle only.
			if (!fault_n_s && fault_n_d && bus_owned_o) begin
				cycle_abort_o <= 1'b1;
				if (cycle_ctrl_read_i && action_req_o) begin
					action_fail_o <= 1'b1;
					action_req_o  <= 1'b0;
					suspended     <= 1'b1;
				end
			end else if (action_req_o && !xfer_pending_i &&
				cycle_done_i) begin
				action_req_o <= 1'b0;
			end
			// A new trigger lifts a suspension and restarts the action.
			if (!action_n_s && action_n_d) begin
				action_req_o <= 1'b1;
				suspended    <= 1'b0;
			end
		end
	end

	// Interrupt pulse aligned with each queue write.
	// A queue write that finds no pending event gives no pulse, so the
	// engine writes the queue only after int_pending_o is seen.
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			int_latched   <= 1'b0;
			done_seen     <= 1'b0;
			int_cnt       <= 4'h0;
			int_pending_o <= 1'b0;
			int_o         <= 1'b0;
		end else begin
			done_seen <= action_req_o;
			// Sources: errors, frames, completed or failed actions.
			if (evt_error_i || evt_frame_i || action_fail_o ||
				(done_seen && !action_req_o))
				int_latched <= 1'b1;
			else if (queue_write_i)
				int_latched <= 1'b0;
			if (queue_write_i && (int_latched || int_pending_o))
				int_cnt <= `HBM_INT_PULSE_CYC;
			else if (int_cnt != 4'h0)
				int_cnt <= int_cnt - 4'h1;
			int_pending_o <= int_latched;
			int_o <= hold_mode_i ? (int_cnt != 4'h0)
				: (int_cnt == 4'h0);
		end
	end

	// The parity and base-code straps are caught once, after reset is released; hold_mode_i is used live.
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			captured      <= 1'b0;
			parity_mode_o <= 1'b0;
			ctrl_base_o   <= 32'h0;
		end else if (!captured) begin
			captured      <= 1'b1;
			parity_mode_o <= hold_mode_i && parity_strap_i;
			ctrl_base_o   <= base_addr;
		end
	end
endmodule // hbm_ctrl

// ==== tb/hbm_props_properties.sv ====
// Checker of mastership, pass-on and interrupt outputs.
`timescale 1ns/1ps
module hbm_props (
	// Watched ports.
	input wire clock_i, reset_i, hold_mode_i, queue_write_i,
	input wire bus_release_ack_i, bus_claim_n_i, master_claimed_n_i,
	input wire bus_take_req_o, release_ack_passon_o, bus_owned_o,
	input wire bus_claim_oe_n_o, master_claimed_oe_n_o,
	input wire grant_passon_n_o, action_fail_o, cycle_abort_o, int_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	sequence s_on2; int_o ##1 int_o ##1 !int_o; endsequence
	sequence s_off2; !int_o ##1 !int_o ##1 int_o; endsequence
	property p_take; !hold_mode_i |-> !bus_take_req_o; endproperty
	a_take: assert property (p_take) else $error("take in grant mode");
	property p_own; hold_mode_i && bus_owned_o |-> bus_take_req_o; endproperty
	a_own: assert property (p_own) else $error("owned without take");
	property p_mcl;
		!hold_mode_i && bus_owned_o |-> !master_claimed_oe_n_o;
	endproperty
	a_mcl: assert property (p_mcl) else $error("owner not claimed");
	property p_pass; release_ack_passon_o |-> hold_mode_i && !bus_take_req_o;
	endproperty
	a_pass: assert property (p_pass) else $error("bad ack pass-on");
	property p_gpass; !grant_passon_n_o |-> !hold_mode_i && bus_claim_oe_n_o;
	endproperty
	a_gpass: assert property (p_gpass) else $error("bad grant pass");
	property p_hreq;
		hold_mode_i && $rose(bus_take_req_o) |-> !$past(bus_release_ack_i, 4);
	endproperty
	a_hreq: assert property (p_hreq) else $error("take during ack");
	property p_gclm; !hold_mode_i && $fell(bus_claim_oe_n_o) |->
		$past(bus_claim_n_i, 4) && $past(master_claimed_n_i, 4);
	endproperty
	a_gclm: assert property (p_gclm) else $error("claim on busy");
	property p_fail; action_fail_o |-> cycle_abort_o; endproperty
	a_fail: assert property (p_fail) else $error("fail w/o abort");
	property p_ion; hold_mode_i && $rose(int_o) |-> s_on2; endproperty
	a_ion: assert property (p_ion) else $error("bad high pulse");
	property p_ioff; !hold_mode_i && $fell(int_o) |-> s_off2; endproperty
	a_ioff: assert property (p_ioff) else $error("bad low pulse");
	property p_iq; $changed(int_o) && int_o == hold_mode_i |->
		$past(queue_write_i, 2) || $past(queue_write_i, 3);
	endproperty
	a_iq: assert property (p_iq) else $error("int w/o write");
endmodule // hbm_props
bind hbm_ctrl hbm_props hbm_props_i (.clock_i, .reset_i, .hold_mode_i,
	.queue_write_i, .bus_release_ack_i, .bus_claim_n_i, .master_claimed_n_i,
	.bus_take_req_o, .release_ack_passon_o, .bus_owned_o, .bus_claim_oe_n_o,
	.master_claimed_oe_n_o, .grant_passon_n_o, .action_fail_o,
	.cycle_abort_o, .int_o);

// ==== tb/hbm_host_model.sv ====
// Host arbiter and peer master model.
`timescale 1ns/1ps
module hbm_host_model (
	// Clock, mode and answer delay.
	input  wire       clock_i,
	input  wire       hold_mode_i,
	input  wire [3:0] lat_i,
	// Device lines and peer wish.
	input  wire       take_req_i,
	input  wire       claim_n_i,
	input  wire       peer_i,
	// Answers.
	output reg        ack_o,
	output reg        grant_n_o,
	output wire       peer_n_o
);
	reg  [3:0] cnt;
	wire       rdy = cnt == lat_i;
	initial {ack_o, grant_n_o, cnt} = 6'h10;
	// A nonzero delay stands for a slow host.
	always @(posedge clock_i) begin
		if (!(take_req_i | peer_i | ~claim_n_i))
			cnt <= 4'h0;
		else if (!rdy)
			cnt <= cnt + 4'h1;
		ack_o <= hold_mode_i & (take_req_i | peer_i) & rdy;
		grant_n_o <= hold_mode_i | claim_n_i | ~rdy;
	end
	assign peer_n_o = ~(peer_i & ~hold_mode_i);
endmodule // hbm_host_model

// ==== tb/hbm_ctrl_bench.sv ====
// Self-checking bench for the bus mastership controller.
`timescale 1ns/1ps
module hbm_ctrl_bench;
	reg clock_i, reset_i, hold_mode_i, parity_strap_i, xfer_pending_i, peer;
	reg cycle_done_i, cycle_ctrl_read_i, evt_error_i, evt_frame_i;
	reg queue_write_i, action_trigger_n_i, bus_fault_n_i;
	reg [4:0] chip_base_code_i;
	reg [3:0] lat;
	integer n_mismatch, checked;
	wire bus_release_ack_i, mastership_grant_n_i, peer_n, bus_take_req_o;
	wire release_ack_passon_o, bus_claim_n_o, bus_claim_oe_n_o, bus_owned_o;
	wire master_claimed_n_o, master_claimed_oe_n_o, grant_passon_n_o;
	wire action_req_o, action_fail_o, cycle_abort_o, int_pending_o, int_o;
	wire parity_mode_o;
	wire [31:0] ctrl_base_o;
	// Open-drain lines with pull-ups.
	wire bus_claim_n_i = (bus_claim_oe_n_o | bus_claim_n_o) & peer_n;
	wire master_claimed_n_i = (master_claimed_oe_n_o | master_claimed_n_o)
		& peer_n;
	wire [9:0] watch = {action_fail_o, action_req_o, int_o, int_pending_o,
		master_claimed_oe_n_o, bus_claim_oe_n_o, grant_passon_n_o,
		release_ack_passon_o, bus_take_req_o, bus_owned_o};
	hbm_ctrl hbm_ctrl_i (.clock_i(clock_i), .reset_i(reset_i),
		.hold_mode_i(hold_mode_i), .parity_strap_i(parity_strap_i),
		.chip_base_code_i(chip_base_code_i),
		.bus_release_ack_i(bus_release_ack_i),
		.bus_take_req_o(bus_take_req_o),
		.release_ack_passon_o(release_ack_passon_o),
		.mastership_grant_n_i(mastership_grant_n_i),
		.bus_claim_n_i(bus_claim_n_i), .bus_claim_n_o(bus_claim_n_o),
		.bus_claim_oe_n_o(bus_claim_oe_n_o),
		.master_claimed_n_i(master_claimed_n_i),
		.master_claimed_n_o(master_claimed_n_o),
		.master_claimed_oe_n_o(master_claimed_oe_n_o),
		.grant_passon_n_o(grant_passon_n_o),
		.action_trigger_n_i(action_trigger_n_i),
		.bus_fault_n_i(bus_fault_n_i), .xfer_pending_i(xfer_pending_i),
		.cycle_done_i(cycle_done_i), .cycle_ctrl_read_i(cycle_ctrl_read_i),
		.evt_error_i(evt_error_i), .evt_frame_i(evt_frame_i),
		.queue_write_i(queue_write_i), .bus_owned_o(bus_owned_o),
		.action_req_o(action_req_o), .action_fail_o(action_fail_o),
		.cycle_abort_o(cycle_abort_o), .int_pending_o(int_pending_o),
		.ctrl_base_o(ctrl_base_o), .parity_mode_o(parity_mode_o),
		.int_o(int_o));
	hbm_host_model hbm_host_model_i (.clock_i(clock_i), .lat_i(lat),
		.hold_mode_i(hold_mode_i), .take_req_i(bus_take_req_o),
		.claim_n_i(bus_claim_n_i), .peer_i(peer), .ack_o(bus_release_ack_i),
		.grant_n_o(mastership_grant_n_i), .peer_n_o(peer_n));
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	task tk(input integer n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR %0s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wt(input string nm, input integer k, input v);
		integer i;
		i = 0;
		while (watch[k] !== v && i < 300) begin
			tk(1);
			i = i + 1;
		end
		chk(nm, watch[k], v);
		if (i == 300)
			report_and_stop;
	endtask
	task rst(input m, input [4:0] c, input s);
		{reset_i, hold_mode_i, parity_strap_i, chip_base_code_i} = {2'h2|m, s, c};
		{xfer_pending_i, cycle_done_i, peer} = 3'h0;
		tk(8);
		reset_i = 1'b0;
		tk(6);
		chk("base", ctrl_base_o,
			{{10{c[4]}}, {6{c[3]}}, {12{c[2]}}, c[1:0], 2'h0});
		chk("parity", parity_mode_o, s);
	endtask
	task t_hold;
		rst(1'b1, 5'h15, 1'b1);
		{xfer_pending_i, cycle_done_i, lat} = 6'h33;
		wt("owned", 0, 1'b1);
		chk("take", bus_take_req_o, 1'b1);
		xfer_pending_i = 1'b0;
		tk(3);
		chk("busy", bus_take_req_o, 1'b1);
		cycle_done_i = 1'b0;
		tk(2);
		chk("free", {bus_take_req_o, bus_owned_o}, 2'h0);
		xfer_pending_i = 1'b1;
		tk(1);
		chk("retake", bus_take_req_o, 1'b0);
		wt("take2", 1, 1'b1);
	endtask
	task t_pass;
		rst(1'b1, 5'h0b, 1'b0);
		peer = 1'b1;
		wt("pass", 2, 1'b1);
		peer = 1'b0;
		wt("pass0", 2, 1'b0);
	endtask
	task t_grant;
		rst(1'b0, 5'h0a, 1'b0);
		{xfer_pending_i, lat} = 5'h10;
		wt("claim", 4, 1'b0);
		wt("gown", 0, 1'b1);
		chk("mcl", {master_claimed_oe_n_o, bus_take_req_o}, 2'h0);
		xfer_pending_i = 1'b0;
		wt("grel", 5, 1'b1);
	endtask
	task t_gpass;
		rst(1'b0, 5'h04, 1'b0);
		peer = 1'b1;
		wt("gpass", 3, 1'b0);
		xfer_pending_i = 1'b1;
		tk(8);
		chk("wait", {bus_owned_o, bus_claim_oe_n_o}, 2'h1);
		peer = 1'b0;
		wt("later", 0, 1'b1);
	endtask
	task t_int(input m);
		rst(m, 5'h1f, 1'b0);
		chk("idle", int_o, !m);
		{evt_error_i, evt_frame_i} = {~m, m};
		tk(1);
		{evt_error_i, evt_frame_i} = 2'h0;
		wt("ipend", 6, 1'b1);
		queue_write_i = 1'b1;
		tk(1);
		queue_write_i = 1'b0;
		wt("int", 7, m);
		tk(1);
		chk("int2", int_o, m);
		tk(1);
		chk("int3", int_o, !m);
	endtask
	task t_fault;
		rst(1'b1, 5'h01, 1'b0);
		lat = 4'h1;
		tk(25000);
		action_trigger_n_i = 1'b0;
		tk(3);
		action_trigger_n_i = 1'b1;
		wt("act", 8, 1'b1);
		wt("fown", 0, 1'b1);
		{cycle_ctrl_read_i, bus_fault_n_i} = 2'h2;
		wt("fail", 9, 1'b1);
		chk("abort", cycle_abort_o, 1'b1);
		{cycle_ctrl_read_i, bus_fault_n_i} = 2'h1;
	endtask
	initial begin
		{reset_i, action_trigger_n_i, bus_fault_n_i, lat} = 7'h70;
		{hold_mode_i, parity_strap_i, chip_base_code_i} = 7'h0;
		{xfer_pending_i, cycle_done_i, cycle_ctrl_read_i, peer} = 4'h0;
		{evt_error_i, evt_frame_i, queue_write_i} = 3'h0;
		n_mismatch = 0;
		checked = 0;
		t_hold;
		t_pass;
		t_grant;
		t_gpass;
		t_int(1'b1);
		t_int(1'b0);
		t_fault;
		report_and_stop;
	end
endmodule // hbm_ctrl_bench
